// *** mimcr_pkg.sv ***
// constants and register map for the interrupt mask and config register slice
package mimcr_pkg;

	// register offsets on the internal register port
	localparam logic [7:0] MIMCR_OFS_MASK_ONE = 8'h43;
	localparam logic [7:0] MIMCR_OFS_MASK_TWO = 8'h44;
	localparam logic [7:0] MIMCR_OFS_SPARE = 8'h45;
	localparam logic [7:0] MIMCR_OFS_INTRUSION_CLEAR_BIT = 8'h46;
	localparam logic [7:0] MIMCR_OFS_VID_DIV = 8'h47;
	localparam logic [7:0] MIMCR_OFS_VID_FOUR = 8'h49;
	localparam logic [7:0] MIMCR_OFS_CFG_TWO = 8'h4A;

	// reset values
	localparam logic [7:0] MIMCR_RST_MASK_ONE = 8'h00;
	localparam logic [7:0] MIMCR_RST_MASK_TWO = 8'h00;
	localparam logic [7:0] MIMCR_RST_SPARE = 8'h00;
	localparam logic [7:0] MIMCR_RST_INTRUSION_CLEAR_BIT = 8'h00;
	localparam logic [3:0] MIMCR_RST_DIV_BITS = 4'h5;
	localparam logic [6:0] MIMCR_RST_VID_FOUR_HI = 7'h40;
	localparam logic [7:0] MIMCR_RST_CFG_TWO = 8'h00;
	localparam logic [7:0] MIMCR_RD_UNMAPPED = 8'h00;

	// field positions
	localparam int MIMCR_INTRUSION_CLEAR_BIT_BIT = 7;
	localparam int MIMCR_DIV_ONE_LSB = 4;
	localparam int MIMCR_DIV_TWO_LSB = 6;
	localparam int MIMCR_CFG_THERMAL_ALARM_LINE_MASK_BIT = 0;
	localparam int MIMCR_CFG_LOCK_LOCAL_BIT = 1;
	localparam int MIMCR_CFG_LOCK_REMOTE_BIT = 2;
	localparam int MIMCR_CFG_ACPI_BIT = 3;
	localparam int MIMCR_CFG_IRQ_THREE_BIT = 6;
	localparam int MIMCR_CFG_IRQ_FIVE_BIT = 7;
	localparam int MIMCR_STAT_THERMAL_ALARM_LINE_BIT = 5;

	// writable bits of configuration two; bits 1 and 2 are set-only
	localparam logic [7:0] MIMCR_CFG_TWO_RW = 8'hC9;
	localparam logic [7:0] MIMCR_CFG_TWO_ONCE = 8'h06;
	// status two bits 2 and 3 are reserved and never raise the alert
	localparam logic [7:0] MIMCR_STAT_TWO_USED = 8'hF3;

	// intrusion clear pulse timing
	localparam int MIMCR_CLK_PERIOD_NS = 8;
	localparam int MIMCR_CI_PULSE_MS = 20;
	localparam int MIMCR_CI_PULSE_CYCLES =
		(MIMCR_CI_PULSE_MS * 1000000 + MIMCR_CLK_PERIOD_NS - 1) /
		MIMCR_CLK_PERIOD_NS;

endpackage

// *** mimcr_pulse.sv ***
// low pulse timer driving the chassis intrusion pin for a fixed cycle count
module mimcr_pulse #(
	parameter int PULSE_CYCLES = mimcr_pkg::MIMCR_CI_PULSE_CYCLES,
	parameter int CNT_W = $clog2(PULSE_CYCLES + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	output logic busy,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [CNT_W-1:0] cnt;
	} mimcr_pulse_state_type;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);

	mimcr_pulse_state_type s_q;
	mimcr_pulse_state_type s_d;

	// count a full period, then report done for one cycle
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (abort) begin
			s_d.busy = 1'b0;
			s_d.cnt = '0;
		end else if (s_q.busy) begin
			if (s_q.cnt == LAST) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.cnt = '0;
			end else begin
				s_d.cnt = s_q.cnt + CNT_W'(1);
			end
		end else if (start) begin
			s_d.busy = 1'b1;
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign done = s_q.done;

endmodule // mimcr_pulse

// *** mimcr_regs.sv ***
// interrupt mask, intrusion clear, voltage id, divisor and config two regs
module mimcr_regs #(
	parameter int CI_PULSE_CYCLES = mimcr_pkg::MIMCR_CI_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [7:0] status_one,
	input wire logic [7:0] status_two,
	input wire logic alert_enable,
	input wire logic defaults_restore_bit,
	input wire logic external_interrupt_mode_bit,
	input wire logic [3:0] voltage_id_low_nibble,
	input wire logic voltage_id_bit_four,
	input wire logic shared_pin_three,
	input wire logic shared_pin_five,
	output logic alert_int_n,
	output logic chassis_intrusion_out,
	output logic chassis_intrusion_oe,
	output logic [3:0] tach_one_divide,
	output logic [3:0] tach_two_divide,
	output logic thermal_alert_masked,
	output logic thermal_acpi_mode,
	output logic local_limit_write_block,
	output logic remote_limit_write_block,
	output logic limit_release,
	output logic irq_three_active,
	output logic irq_five_active
);

	typedef struct packed {
		logic [7:0] mask_one;
		logic [7:0] mask_two;
		logic [7:0] spare;
		logic [7:0] intrusion_clear_bit;
		logic [3:0] div_bits;
		logic [6:0] vid_four_hi;
		logic [7:0] cfg_two;
		logic [7:0] rdata;
		logic rvalid;
		logic alert_n;
		logic ci_out;
		logic [3:0] div_one;
		logic [3:0] div_two;
		logic irq_three;
		logic irq_five;
		logic release_limits;
	} mimcr_state_type;

	// divisor code to divide factor: 00->1, 01->2, 10->4, 11->8
	function automatic logic [3:0] mimcr_div_decode(input logic [1:0] code);
		logic [3:0] f;
		f = 4'h1;
		case (code)
			2'b00: f = 4'h1;
			2'b01: f = 4'h2;
			2'b10: f = 4'h4;
			default: f = 4'h8;
		endcase
		return f;
	endfunction

	mimcr_state_type s_q;
	mimcr_state_type s_d;
	logic wr_mask_one;
	logic wr_mask_two;
	logic wr_spare;
	logic wr_ci;
	logic wr_vid_div;
	logic wr_vid_four;
	logic wr_cfg_two;
	logic pulse_start;
	logic pulse_busy;
	logic pulse_done;
	logic irq_three_now;
	logic irq_five_now;
	logic [7:0] stat_two_eff;
	logic alert_pending;
	logic [7:0] rd_mux;

	// address decode for writes
	always_comb begin
		wr_mask_one = 1'b0;
		wr_mask_two = 1'b0;
		wr_spare = 1'b0;
		wr_ci = 1'b0;
		wr_vid_div = 1'b0;
		wr_vid_four = 1'b0;
		wr_cfg_two = 1'b0;
		if (!reg_wr_en) begin
			wr_mask_one = 1'b0;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_MASK_ONE) begin
			wr_mask_one = 1'b1;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_MASK_TWO) begin
			wr_mask_two = 1'b1;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_SPARE) begin
			wr_spare = 1'b1;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_INTRUSION_CLEAR_BIT) begin
			wr_ci = 1'b1;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_VID_DIV) begin
			wr_vid_div = 1'b1;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_VID_FOUR) begin
			wr_vid_four = 1'b1;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_CFG_TWO) begin
			wr_cfg_two = 1'b1;
		end
	end

	// read mux; the pin bits are sampled live, not stored
	always_comb begin
		rd_mux = mimcr_pkg::MIMCR_RD_UNMAPPED;
		if (reg_addr == mimcr_pkg::MIMCR_OFS_MASK_ONE) begin
			rd_mux = s_q.mask_one;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_MASK_TWO) begin
			rd_mux = s_q.mask_two;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_SPARE) begin
			rd_mux = s_q.spare;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_INTRUSION_CLEAR_BIT) begin
			rd_mux = s_q.intrusion_clear_bit;
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_VID_DIV) begin
			rd_mux = {s_q.div_bits, voltage_id_low_nibble};
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_VID_FOUR) begin
			rd_mux = {s_q.vid_four_hi, voltage_id_bit_four};
		end else if (reg_addr == mimcr_pkg::MIMCR_OFS_CFG_TWO) begin
			rd_mux = s_q.cfg_two;
		end
	end

	// shared pins count as interrupts only in interrupt mode
	assign irq_three_now = external_interrupt_mode_bit &
		s_q.cfg_two[mimcr_pkg::MIMCR_CFG_IRQ_THREE_BIT] &
		shared_pin_three;
	assign irq_five_now = external_interrupt_mode_bit &
		s_q.cfg_two[mimcr_pkg::MIMCR_CFG_IRQ_FIVE_BIT] &
		shared_pin_five;

	// thermal events leave the alert path only; the thermal pin is elsewhere
	always_comb begin
		stat_two_eff = status_two & mimcr_pkg::MIMCR_STAT_TWO_USED;
		if (s_q.cfg_two[mimcr_pkg::MIMCR_CFG_THERMAL_ALARM_LINE_MASK_BIT]) begin
			stat_two_eff[mimcr_pkg::MIMCR_STAT_THERMAL_ALARM_LINE_BIT] = 1'b0;
		end
	end

	// unmasked status bits and both shared-pin interrupts ORed together; alert_enable gates this later, in the next-state logic
	assign alert_pending = (|(status_one & ~s_q.mask_one)) |
		(|(stat_two_eff & ~s_q.mask_two)) |
		irq_three_now | irq_five_now;

	// a pulse starts only from idle; a second write while low is absorbed
	assign pulse_start = wr_ci & reg_wdata[mimcr_pkg::MIMCR_INTRUSION_CLEAR_BIT_BIT] &
		~pulse_busy & ~defaults_restore_bit;

	// next-state logic for all registers
	always_comb begin
		s_d = s_q;
		s_d.rvalid = reg_rd_en;
		s_d.rdata = reg_rd_en ? rd_mux : s_q.rdata;
		s_d.alert_n = ~(alert_enable & alert_pending);
		s_d.irq_three = irq_three_now;
		s_d.irq_five = irq_five_now;
		s_d.ci_out = 1'b0;
		s_d.release_limits = defaults_restore_bit;
		if (wr_mask_one) begin
			s_d.mask_one = reg_wdata;
		end
		if (wr_mask_two) begin
			s_d.mask_two = reg_wdata;
		end
		if (wr_spare) begin
			s_d.spare = reg_wdata;
		end
		// self clear at pulse end; a fresh write of one wins
		if (pulse_done) begin
			s_d.intrusion_clear_bit[mimcr_pkg::MIMCR_INTRUSION_CLEAR_BIT_BIT] = 1'b0;
		end
		if (wr_ci) begin
			s_d.intrusion_clear_bit[6:0] = reg_wdata[6:0];
			if (reg_wdata[mimcr_pkg::MIMCR_INTRUSION_CLEAR_BIT_BIT]) begin
				s_d.intrusion_clear_bit[mimcr_pkg::MIMCR_INTRUSION_CLEAR_BIT_BIT] = 1'b1;
			end
		end
		if (wr_vid_div) begin
			s_d.div_bits = reg_wdata[7:4];
		end
		if (wr_vid_four) begin
			s_d.vid_four_hi = reg_wdata[7:1];
		end
		// lock bits can be set by a write but never cleared by one
		if (wr_cfg_two) begin
			s_d.cfg_two = (reg_wdata & mimcr_pkg::MIMCR_CFG_TWO_RW) |
				(s_q.cfg_two & mimcr_pkg::MIMCR_CFG_TWO_ONCE) |
				(reg_wdata & mimcr_pkg::MIMCR_CFG_TWO_ONCE);
		end
		// restore overrides any write in the same cycle except one to the spare register
		if (defaults_restore_bit) begin
			s_d.mask_one = mimcr_pkg::MIMCR_RST_MASK_ONE;
			s_d.mask_two = mimcr_pkg::MIMCR_RST_MASK_TWO;
			s_d.intrusion_clear_bit = mimcr_pkg::MIMCR_RST_INTRUSION_CLEAR_BIT;
			s_d.div_bits = mimcr_pkg::MIMCR_RST_DIV_BITS;
			s_d.vid_four_hi = mimcr_pkg::MIMCR_RST_VID_FOUR_HI;
			s_d.cfg_two = mimcr_pkg::MIMCR_RST_CFG_TWO;
		end
		s_d.div_one = mimcr_div_decode(
			s_d.div_bits[mimcr_pkg::MIMCR_DIV_ONE_LSB-4 +: 2]);
		s_d.div_two = mimcr_div_decode(
			s_d.div_bits[mimcr_pkg::MIMCR_DIV_TWO_LSB-4 +: 2]);
	end

	// state register; power-on values are constants
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.mask_one <= mimcr_pkg::MIMCR_RST_MASK_ONE;
			s_q.mask_two <= mimcr_pkg::MIMCR_RST_MASK_TWO;
			s_q.spare <= mimcr_pkg::MIMCR_RST_SPARE;
			s_q.intrusion_clear_bit <= mimcr_pkg::MIMCR_RST_INTRUSION_CLEAR_BIT;
			s_q.div_bits <= mimcr_pkg::MIMCR_RST_DIV_BITS;
			s_q.vid_four_hi <= mimcr_pkg::MIMCR_RST_VID_FOUR_HI;
			s_q.cfg_two <= mimcr_pkg::MIMCR_RST_CFG_TWO;
			s_q.rdata <= 8'h00;
			s_q.rvalid <= 1'b0;
			s_q.alert_n <= 1'b1;
			s_q.ci_out <= 1'b0;
			s_q.div_one <= 4'h2;
			s_q.div_two <= 4'h2;
			s_q.irq_three <= 1'b0;
			s_q.irq_five <= 1'b0;
			s_q.release_limits <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// intrusion pin is driven low only while the timer runs
	mimcr_pulse #(
		.PULSE_CYCLES(CI_PULSE_CYCLES)
	) u_ci_pulse (
		.clk(clk),
		.rst_n(rst_n),
		.start(pulse_start),
		.abort(defaults_restore_bit),
		.busy(pulse_busy),
		.done(pulse_done)
	);

	assign reg_rdata = s_q.rdata;
	assign reg_rvalid = s_q.rvalid;
	assign alert_int_n = s_q.alert_n;
	assign chassis_intrusion_out = s_q.ci_out;
	assign chassis_intrusion_oe = pulse_busy;
	assign tach_one_divide = s_q.div_one;
	assign tach_two_divide = s_q.div_two;
	assign thermal_alert_masked =
		s_q.cfg_two[mimcr_pkg::MIMCR_CFG_THERMAL_ALARM_LINE_MASK_BIT];
	assign thermal_acpi_mode =
		s_q.cfg_two[mimcr_pkg::MIMCR_CFG_ACPI_BIT];
	assign local_limit_write_block =
		s_q.cfg_two[mimcr_pkg::MIMCR_CFG_LOCK_LOCAL_BIT];
	assign remote_limit_write_block =
		s_q.cfg_two[mimcr_pkg::MIMCR_CFG_LOCK_REMOTE_BIT];
	assign limit_release = s_q.release_limits;
	assign irq_three_active = s_q.irq_three;
	assign irq_five_active = s_q.irq_five;

endmodule // mimcr_regs

// *** mimcr_regs_asserts.sv ***
// port-level assertions for the mask and configuration register slice
module mimcr_regs_chk #(
	parameter int CI_PULSE_CYCLES = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic alert_enable,
	input wire logic defaults_restore_bit,
	input wire logic alert_int_n,
	input wire logic chassis_intrusion_out,
	input wire logic chassis_intrusion_oe,
	input wire logic [3:0] tach_one_divide,
	input wire logic [3:0] tach_two_divide,
	input wire logic local_limit_write_block
);
	logic [31:0] low_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// cycles the intrusion pin has been held low so far
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			low_q <= '0;
		else
			low_q <= chassis_intrusion_oe ? low_q + 32'h1 : '0;
	end
	// a write that no restore pulse overrides
	sequence s_wr(logic [7:0] a);
		reg_wr_en && reg_addr == a && !defaults_restore_bit;
	endsequence
	sequence s_ci_go;
		s_wr(8'h46) ##0 reg_wdata[7] && !chassis_intrusion_oe;
	endsequence
	property p_alert_off;
		!alert_enable |=> alert_int_n;
	endproperty
	property p_div_one;
		s_wr(8'h47) |=> tach_one_divide == 4'h1 << $past(reg_wdata[5:4]);
	endproperty
	property p_div_two;
		s_wr(8'h47) |=> tach_two_divide == 4'h1 << $past(reg_wdata[7:6]);
	endproperty
	property p_ci_go;
		s_ci_go |=> chassis_intrusion_oe;
	endproperty
	// a restore may cut the pulse short, nothing else may
	property p_ci_len;
		$fell(chassis_intrusion_oe) |->
			low_q == CI_PULSE_CYCLES || $past(defaults_restore_bit);
	endproperty
	property p_ci_out;
		chassis_intrusion_out == 1'b0;
	endproperty
	property p_lock;
		local_limit_write_block && !defaults_restore_bit
			|=> local_limit_write_block;
	endproperty
	property p_restore;
		defaults_restore_bit |=> !local_limit_write_block &&
			!chassis_intrusion_oe && tach_one_divide == 4'h2;
	endproperty
	a_alert_off: assert property (p_alert_off)
		else $error("alert low while disabled");
	a_div_one: assert property (p_div_one)
		else $error("tach one divisor wrong");
	a_div_two: assert property (p_div_two)
		else $error("tach two divisor wrong");
	a_ci_go: assert property (p_ci_go)
		else $error("intrusion pulse did not start");
	a_ci_len: assert property (p_ci_len)
		else $error("intrusion pulse length wrong");
	a_ci_out: assert property (p_ci_out)
		else $error("intrusion pin driven high");
	a_lock: assert property (p_lock)
		else $error("limit lock cleared");
	a_restore: assert property (p_restore)
		else $error("restore incomplete");
endmodule // mimcr_regs_chk

bind mimcr_regs mimcr_regs_chk #(.CI_PULSE_CYCLES(CI_PULSE_CYCLES)) u_chk (
	.clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata, .alert_enable,
	.defaults_restore_bit, .alert_int_n, .chassis_intrusion_out,
	.chassis_intrusion_oe, .tach_one_divide, .tach_two_divide,
	.local_limit_write_block);

// *** mimcr_host.sv ***
// register port host issuing single-byte reads and writes
module mimcr_host (
	input wire logic clk,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// idle lines show the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// answer stands one cycle, taken mid-cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		v = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule // mimcr_host

// *** mimcr_regs_bench.sv ***
// self-checking bench for the mask and configuration register slice
module mimcr_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 16;
	logic clk, rst_n, reg_wr_en, reg_rd_en, reg_rvalid, alert_enable, rv;
	logic defaults_restore_bit, external_interrupt_mode_bit, limit_release;
	logic voltage_id_bit_four, shared_pin_three, shared_pin_five;
	logic alert_int_n, chassis_intrusion_out, chassis_intrusion_oe;
	logic thermal_alert_masked, thermal_acpi_mode, irq_three_active;
	logic local_limit_write_block, remote_limit_write_block, irq_five_active;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, status_one, status_two, rd;
	logic [3:0] voltage_id_low_nibble, tach_one_divide, tach_two_divide;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int k, n;
	// address, write data, readback
	logic [23:0] rows [8] = '{24'h45A5A5, 24'h435A5A, 24'h44FFFF,
		24'h467F7F, 24'h47FFF9, 24'h49FEFF, 24'h4AFFCF, 24'h503300};
	// address, data, status one, status two, enable in bit 3, alert bit 2
	logic [35:0] arows [8] = '{36'h43_00_01_00_8, 36'h43_01_01_00_C,
		36'h43_01_01_0C_C, 36'h4A_00_01_20_8, 36'h4A_01_01_20_C,
		36'h4A_08_01_20_4, 36'h4A_08_01_20_8, 36'h44_20_01_20_C};
	// address and reset value, pins at 9 and 1
	logic [15:0] rvals [7] = '{16'h4300, 16'h4400, 16'h4500, 16'h4600,
		16'h4759, 16'h4981, 16'h4A00};
	mimcr_regs #(.CI_PULSE_CYCLES(PW)) dut (.clk, .rst_n, .reg_wr_en,
		.reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.status_one, .status_two, .alert_enable, .defaults_restore_bit,
		.external_interrupt_mode_bit, .voltage_id_low_nibble,
		.voltage_id_bit_four, .shared_pin_three, .shared_pin_five,
		.alert_int_n, .chassis_intrusion_out, .chassis_intrusion_oe,
		.tach_one_divide, .tach_two_divide, .thermal_alert_masked,
		.thermal_acpi_mode, .local_limit_write_block,
		.remote_limit_write_block, .limit_release, .irq_three_active,
		.irq_five_active);
	mimcr_host host (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid);
	task automatic conclude();
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bchk(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rd, rv);
		bchk("rvalid", 1'b1, rv);
		chk("rdata", e, rd);
	endtask
	// registered outputs settle one edge after an input change
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic restore();
		@(posedge clk);
		defaults_restore_bit <= 1'b1;
		@(posedge clk);
		defaults_restore_bit <= 1'b0;
		@(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard, far above the roughly 150 cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		rst_n = 1'b0;
		{alert_enable, defaults_restore_bit} = 2'h0;
		{external_interrupt_mode_bit, shared_pin_three} = 2'h0;
		shared_pin_five = 1'b0;
		{status_one, status_two} = 16'h0000;
		voltage_id_low_nibble = 4'h9;
		voltage_id_bit_four = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 8; k++) begin
			host.wr(rows[k][23:16], rows[k][15:8]);
			rchk(rows[k][23:16], rows[k][7:0]);
		end
		bchk("thermal_alarm_line_mask", 1'b1, thermal_alert_masked);
		host.wr(8'h4A, 8'h00);
		rchk(8'h4A, 8'h06);
		restore();
		bchk("release", 1'b1, limit_release);
		bchk("lock", 1'b0, remote_limit_write_block);
		rchk(8'h43, 8'h00);
		rchk(8'h47, 8'h59);
		// every divisor code, fields set apart to catch a swap
		for (k = 0; k < 4; k++) begin
			host.wr(8'h47, {2'(3 - k), 2'(k), 4'h0});
			@(negedge clk);
			chk("div_one", {4'h0, 4'h1 << k}, {4'h0, tach_one_divide});
			chk("div_two", {4'h0, 4'h8 >> k}, {4'h0, tach_two_divide});
		end
		for (k = 0; k < 8; k++) begin
			host.wr(arows[k][35:28], arows[k][27:20]);
			status_one <= arows[k][19:12];
			status_two <= arows[k][11:4];
			alert_enable <= arows[k][3];
			settle();
			bchk("alert", arows[k][2], alert_int_n);
		end
		bchk("acpi", 1'b1, thermal_acpi_mode);
		// shared pins count only in interrupt mode
		host.wr(8'h4A, 8'hC0);
		shared_pin_three <= 1'b1;
		shared_pin_five <= 1'b1;
		settle();
		bchk("irq_three", 1'b0, irq_three_active);
		external_interrupt_mode_bit <= 1'b1;
		settle();
		bchk("irq_five", 1'b1, irq_five_active);
		bchk("irq_three", 1'b1, irq_three_active);
		bchk("alert", 1'b0, alert_int_n);
		host.wr(8'h4A, 8'h80);
		settle();
		bchk("irq_three", 1'b0, irq_three_active);
		// full pulse, then one cut short by a restore
		host.wr(8'h46, 8'h80);
		n = 0;
		@(negedge clk);
		while (chassis_intrusion_oe === 1'b1 && n < 99) begin
			n++;
			@(negedge clk);
		end
		chk("pulse", 8'(PW), 8'(n));
		rchk(8'h46, 8'h00);
		host.wr(8'h46, 8'h80);
		rchk(8'h46, 8'h80);
		bchk("ci_oe", 1'b1, chassis_intrusion_oe);
		bchk("ci_out", 1'b0, chassis_intrusion_out);
		restore();
		rchk(8'h46, 8'h00);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 7; k++)
			rchk(rvals[k][15:8], rvals[k][7:0]);
		chk("div_one", 8'h02, {4'h0, tach_one_divide});
		conclude();
	end
endmodule // mimcr_regs_bench
